// file: rtl/apmix_params.svh
// constants for the port-1 output mixer: offsets, resets, widths, bus codes
// How it works
// - each output channel has a 7-bit source bitmap, one bit per input.
// - a bitmap bit of one mixes that input in; zero leaves it out.
// - bit 7 of a source register is reserved, ignored and reads zero.
// - left output bitmap resets to 0x1, filter 1 left only.
// - right output bitmap resets to 0x4, filter 2 left only.
// - path gain is a 5-bit code, -42 dB at zero, 1.5 dB per step.
// - code 11100 is unity; codes above boost up to +4.5 dB at 11111.
// - every path gain field resets to 0x1C, unity.
// - the tone input has its own gain field per output channel.
// - received right input reaches the left output through its own gain.
`ifndef APMIX_PARAMS_SVH
`define APMIX_PARAMS_SVH

// register indices as printed; byte address is four times the index
`define APMIX_IDX_W         10
`define APMIX_IDX_L_SRC     10'h05C
`define APMIX_IDX_L_F1L     10'h05D
`define APMIX_IDX_L_F1R     10'h05E
`define APMIX_IDX_L_F2L     10'h05F
`define APMIX_IDX_L_F2R     10'h060
`define APMIX_IDX_L_TONE    10'h061
`define APMIX_IDX_L_RXL     10'h062
`define APMIX_IDX_L_RXR     10'h063
`define APMIX_IDX_R_SRC     10'h064
`define APMIX_IDX_R_F1L     10'h065
`define APMIX_IDX_R_F1R     10'h066
`define APMIX_IDX_R_F2L     10'h067
`define APMIX_IDX_R_F2R     10'h068
`define APMIX_IDX_R_TONE    10'h069
`define APMIX_IDX_R_RXL     10'h06A
`define APMIX_IDX_R_RXR     10'h06B
`define APMIX_IDX_STATUS    10'h0F0

// field widths and source bit positions
`define APMIX_ADDR_W        12
`define APMIX_DATA_W        32
`define APMIX_SRC_W         7
`define APMIX_GAIN_W        5
`define APMIX_NUM_SRC       7
`define APMIX_NUM_CH        2
`define APMIX_SMP_W         24
`define APMIX_BIT_TONE      4
`define APMIX_BIT_RXR       6

// reset values
`define APMIX_L_SRC_RST     7'h01
`define APMIX_R_SRC_RST     7'h04
`define APMIX_GAIN_UNITY    5'h1C
`define APMIX_GAIN_RST      `APMIX_GAIN_UNITY

// arithmetic: gain coefficient is unsigned Q2.14
`define APMIX_COEF_W        16
`define APMIX_COEF_FRAC     14
`define APMIX_TERM_W        26
`define APMIX_SUM_W         29

// status bits and bus answers
`define APMIX_ST_CLIP_L     0
`define APMIX_ST_CLIP_R     1
`define APMIX_RESP_OKAY     2'h0
`define APMIX_RESP_SLVERR   2'h2

`endif

// file: rtl/apmix_pkg.sv
// types shared by the port-1 output mixer
`include "apmix_params.svh"
package apmix_pkg;
    typedef logic signed [`APMIX_SMP_W-1:0]  apmix_smp_t;
    typedef logic signed [`APMIX_TERM_W-1:0] apmix_term_t;
    typedef logic        [`APMIX_GAIN_W-1:0] apmix_gain_t;
    typedef logic        [`APMIX_SRC_W-1:0]  apmix_bitmap_t;

    // seven input samples with one common strobe
    typedef struct packed {
        logic                               valid;
        logic [`APMIX_NUM_SRC-1:0][`APMIX_SMP_W-1:0] smp;
    } apmix_src_t;

    // mixed stereo pair toward the port transmitter
    typedef struct packed {
        logic       valid;
        apmix_smp_t left;
        apmix_smp_t right;
    } apmix_out_t;

    typedef enum logic [1:0] {
        APMIX_W_IDLE = 2'b01,
        APMIX_W_RESP = 2'b10
    } apmix_wst_t;

    typedef enum logic [1:0] {
        APMIX_R_IDLE = 2'b01,
        APMIX_R_DATA = 2'b10
    } apmix_rst_t;
endpackage

// file: rtl/apmix_gain.sv
// one mixer path: gain code to coefficient, multiply, gate by selection
`include "apmix_params.svh"
module apmix_gain (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  load,
    input  wire logic                  select,
    input  wire apmix_pkg::apmix_gain_t gain,
    input  wire apmix_pkg::apmix_smp_t  smp,
    output apmix_pkg::apmix_term_t     term_q
);
    import apmix_pkg::*;

    logic [`APMIX_COEF_W-1:0]          coef;
    logic signed [`APMIX_COEF_W:0]     coef_s;
    logic signed [`APMIX_SMP_W+`APMIX_COEF_W:0] prod;
    apmix_term_t                       term_d;

    // -42 dB at code 0, 1.5 dB steps, unity 0x4000 at 0x1C
    always_comb begin
        case (gain)
            5'h00: coef = 16'h0082;
            5'h01: coef = 16'h009B;
            5'h02: coef = 16'h00B8;
            5'h03: coef = 16'h00DA;
            5'h04: coef = 16'h0104;
            5'h05: coef = 16'h0135;
            5'h06: coef = 16'h016F;
            5'h07: coef = 16'h01B4;
            5'h08: coef = 16'h0206;
            5'h09: coef = 16'h0268;
            5'h0A: coef = 16'h02DC;
            5'h0B: coef = 16'h0366;
            5'h0C: coef = 16'h040A;
            5'h0D: coef = 16'h04CD;
            5'h0E: coef = 16'h05B4;
            5'h0F: coef = 16'h06C7;
            5'h10: coef = 16'h080F;
            5'h11: coef = 16'h0993;
            5'h12: coef = 16'h0B62;
            5'h13: coef = 16'h0D87;
            5'h14: coef = 16'h1013;
            5'h15: coef = 16'h131B;
            5'h16: coef = 16'h16B5;
            5'h17: coef = 16'h1AFD;
            5'h18: coef = 16'h2013;
            5'h19: coef = 16'h261F;
            5'h1A: coef = 16'h2D4F;
            5'h1B: coef = 16'h35D9;
            5'h1C: coef = 16'h4000;
            5'h1D: coef = 16'h4C10;
            5'h1E: coef = 16'h5A67;
            5'h1F: coef = 16'h6B71;
            default: coef = 16'h4000;
        endcase
    end

    // truncation toward minus infinity, cheaper than rounding
    assign coef_s = $signed({1'b0, coef});
    assign prod   = smp * coef_s;
    // deselected path adds exactly nothing whatever its gain
    assign term_d = select ? prod[`APMIX_COEF_FRAC+`APMIX_TERM_W-1:`APMIX_COEF_FRAC]
                           : '0;

    // product stage, advanced only on an input sample
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            term_q <= '0;
        end else if (load) begin
            term_q <= term_d;
        end
    end
endmodule // apmix_gain

// file: rtl/apmix_top.sv
// port-1 output mixer: axi4-lite register file and two seven-input mixers
`include "apmix_params.svh"
module apmix_top (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // axi4-lite write address
    input  wire logic [`APMIX_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    // axi4-lite write data
    input  wire logic [`APMIX_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // axi4-lite read address
    input  wire logic [`APMIX_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    // axi4-lite read data
    output logic [`APMIX_DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // audio streams
    input  wire apmix_pkg::apmix_src_t       src_in,
    output apmix_pkg::apmix_out_t            mix_out
);
    import apmix_pkg::*;

    localparam int NCH = `APMIX_NUM_CH;
    localparam int NSRC = `APMIX_NUM_SRC;

    // ---- write channel state
    apmix_wst_t                    wst_q, wst_d;
    logic                          aw_hold_q, aw_hold_d;
    logic                          w_hold_q, w_hold_d;
    logic [`APMIX_ADDR_W-1:0]      waddr_q;
    logic [`APMIX_DATA_W-1:0]      wdata_q;
    logic                          wlane0_q;
    logic                          awready_q, wready_q;
    logic                          bvalid_q;
    logic [1:0]                    bresp_q;

    // ---- read channel state
    apmix_rst_t                    rst_q, rst_d;
    logic                          arready_q, rvalid_q;
    logic [`APMIX_DATA_W-1:0]      rdata_q;
    logic [1:0]                    rresp_q;

    // ---- configuration and status
    apmix_bitmap_t                 src_q [NCH];
    apmix_gain_t                   gain_q [NCH][NSRC];
    logic [NCH-1:0]                clip_q;

    // ---- datapath
    apmix_term_t                   term_w [NCH][NSRC];
    logic signed [`APMIX_SUM_W-1:0] sum_w [NCH];
    apmix_smp_t                    sat_w [NCH];
    logic [NCH-1:0]                ovf_w;
    logic                          prod_vld_q;
    apmix_out_t                    out_q;

    // handshakes
    wire aw_fire = s_axi_awvalid & awready_q;
    wire w_fire  = s_axi_wvalid & wready_q;
    wire ar_fire = s_axi_arvalid & arready_q;
    wire b_done  = bvalid_q & s_axi_bready;
    wire r_done  = rvalid_q & s_axi_rready;

    // write commits in the cycle both halves are held
    wire wr_commit = aw_hold_q & w_hold_q & (wst_q == APMIX_W_IDLE);

    // write address decode: index, bank, slot
    wire [`APMIX_IDX_W-1:0] widx   = waddr_q[`APMIX_ADDR_W-1:2];
    wire [`APMIX_IDX_W-1:0] woff   = widx - `APMIX_IDX_L_SRC;
    wire                    w_algn = (waddr_q[1:0] == 2'h0);
    wire                    w_mix  = w_algn & (widx >= `APMIX_IDX_L_SRC)
                                   & (widx <= `APMIX_IDX_R_RXR);
    wire                    w_stat = w_algn & (widx == `APMIX_IDX_STATUS);
    wire                    w_hit  = w_mix | w_stat;
    wire                    w_ch   = woff[3];
    wire [2:0]              w_slot = woff[2:0];
    wire                    w_en   = wr_commit & wlane0_q;

    // read address decode, straight off the bus since it is taken at once
    wire [`APMIX_IDX_W-1:0] ridx   = s_axi_araddr[`APMIX_ADDR_W-1:2];
    wire [`APMIX_IDX_W-1:0] roff   = ridx - `APMIX_IDX_L_SRC;
    wire                    r_algn = (s_axi_araddr[1:0] == 2'h0);
    wire                    r_mix  = r_algn & (ridx >= `APMIX_IDX_L_SRC)
                                   & (ridx <= `APMIX_IDX_R_RXR);
    wire                    r_stat = r_algn & (ridx == `APMIX_IDX_STATUS);
    wire                    r_ch   = roff[3];
    wire [2:0]              r_slot = roff[2:0];
    wire [2:0]              r_gsel = r_slot - 3'h1;

    // read data select; reserved bits, bit 7 included, read zero
    wire [`APMIX_DATA_W-1:0] rd_src  = {25'h0, src_q[r_ch]};
    wire [`APMIX_DATA_W-1:0] rd_gain = {27'h0, gain_q[r_ch][r_gsel]};
    wire [`APMIX_DATA_W-1:0] rd_stat = {30'h0, clip_q};
    wire [`APMIX_DATA_W-1:0] rd_mix  = (r_slot == 3'h0) ? rd_src : rd_gain;
    wire [`APMIX_DATA_W-1:0] rd_word = r_mix  ? rd_mix
                                     : r_stat ? rd_stat
                                     : '0;

    // write side next state
    always_comb begin
        wst_d     = wst_q;
        aw_hold_d = aw_hold_q | aw_fire;
        w_hold_d  = w_hold_q | w_fire;
        case (wst_q)
            APMIX_W_IDLE: begin
                if (wr_commit) begin
                    wst_d     = APMIX_W_RESP;
                    aw_hold_d = 1'b0;
                    w_hold_d  = 1'b0;
                end
            end
            APMIX_W_RESP: begin
                if (b_done) begin
                    wst_d = APMIX_W_IDLE;
                end
            end
            default: begin
                wst_d = APMIX_W_IDLE;
            end
        endcase
    end

    // write side registers; each channel closes once its half is held
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wst_q     <= APMIX_W_IDLE;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
        end else begin
            wst_q     <= wst_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            awready_q <= ~aw_hold_d & (wst_d == APMIX_W_IDLE);
            wready_q  <= ~w_hold_d & (wst_d == APMIX_W_IDLE);
        end
    end

    // captured write payload
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waddr_q  <= '0;
            wdata_q  <= '0;
            wlane0_q <= 1'b0;
        end else begin
            if (aw_fire) begin
                waddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_q  <= s_axi_wdata;
                wlane0_q <= s_axi_wstrb[0];
            end
        end
    end

    // write response; unmapped address answers slverr
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `APMIX_RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_q <= 1'b1;
            bresp_q  <= w_hit ? `APMIX_RESP_OKAY : `APMIX_RESP_SLVERR;
        end else if (b_done) begin
            bvalid_q <= 1'b0;
        end
    end

    // read side next state
    always_comb begin
        rst_d = rst_q;
        case (rst_q)
            APMIX_R_IDLE: begin
                if (ar_fire) begin
                    rst_d = APMIX_R_DATA;
                end
            end
            APMIX_R_DATA: begin
                if (r_done) begin
                    rst_d = APMIX_R_IDLE;
                end
            end
            default: begin
                rst_d = APMIX_R_IDLE;
            end
        endcase
    end

    // read side registers; data is sampled at the address handshake
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rst_q     <= APMIX_R_IDLE;
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= `APMIX_RESP_OKAY;
        end else begin
            rst_q     <= rst_d;
            arready_q <= (rst_d == APMIX_R_IDLE);
            rvalid_q  <= (rst_d == APMIX_R_DATA);
            if (ar_fire) begin
                rdata_q <= rd_word;
                rresp_q <= (r_mix | r_stat) ? `APMIX_RESP_OKAY : `APMIX_RESP_SLVERR;
            end
        end
    end

    // per channel: source bitmap, seven gains, seven path multipliers
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_ch
            wire src_we = w_en & w_mix & (w_ch == c[0]) & (w_slot == 3'h0);

            // only bits 6:0 are stored, so bit 7 never steers mixing
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    src_q[c] <= (c == 0) ? `APMIX_L_SRC_RST
                                         : `APMIX_R_SRC_RST;
                end else if (src_we) begin
                    src_q[c] <= wdata_q[`APMIX_SRC_W-1:0];
                end
            end

            for (genvar s = 0; s < NSRC; s++) begin : g_path
                // slot s+1 holds the gain for source bit s, tone and rx right
                // included, so every path level is set on its own
                wire gain_we = w_en & w_mix & (w_ch == c[0])
                             & (w_slot == 3'(s + 1));

                always_ff @(posedge clock) begin
                    if (!rst_n) begin
                        gain_q[c][s] <= `APMIX_GAIN_RST;
                    end else if (gain_we) begin
                        gain_q[c][s] <= wdata_q[`APMIX_GAIN_W-1:0];
                    end
                end

                // bitmap bit s gates exactly input s
                apmix_gain u_path (
                    .clock  (clock),
                    .rst_n  (rst_n),
                    .load   (src_in.valid),
                    .select (src_q[c][s]),
                    .gain   (gain_q[c][s]),
                    .smp    (src_in.smp[s]),
                    .term_q (term_w[c][s])
                );
            end

            // saturate the wide sum back to the sample width
            wire sgn = sum_w[c][`APMIX_SUM_W-1];
            wire [`APMIX_SUM_W-`APMIX_SMP_W-1:0] top =
                sum_w[c][`APMIX_SUM_W-2:`APMIX_SMP_W-1];
            wire pos_ovf = ~sgn & (|top);
            wire neg_ovf = sgn & ~(&top);
            assign ovf_w[c] = pos_ovf | neg_ovf;
            assign sat_w[c] = pos_ovf ? {1'b0, {(`APMIX_SMP_W-1){1'b1}}}
                            : neg_ovf ? {1'b1, {(`APMIX_SMP_W-1){1'b0}}}
                            : sum_w[c][`APMIX_SMP_W-1:0];

            // sticky clip flag; a new clip beats a software clear
            wire clip_clr = w_en & w_stat & wdata_q[c];
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    clip_q[c] <= 1'b0;
                end else begin
                    clip_q[c] <= (prod_vld_q & ovf_w[c]) | (clip_q[c] & ~clip_clr);
                end
            end
        end
    endgenerate

    // sum of the gated terms; deselected paths already give zero
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            sum_w[c] = '0;
            for (int s = 0; s < NSRC; s++) begin
                sum_w[c] = sum_w[c] + `APMIX_SUM_W'(term_w[c][s]);
            end
        end
    end

    // two-stage pipeline: products, then sum and saturate
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prod_vld_q <= 1'b0;
        end else begin
            prod_vld_q <= src_in.valid;
        end
    end

    // output pair holds between strobes; valid is a one-cycle pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_q <= '0;
        end else begin
            out_q.valid <= prod_vld_q;
            if (prod_vld_q) begin
                out_q.left  <= sat_w[0];
                out_q.right <= sat_w[1];
            end
        end
    end

    // every output straight from a flip-flop
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign mix_out       = out_q;
endmodule // apmix_top

// file: test/apmix_sink.sv
// port transmitter stand-in: keeps the last mixed pair and counts results
module apmix_sink (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire apmix_pkg::apmix_out_t mix_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import apmix_pkg::*;
    apmix_smp_t got_l_q;
    apmix_smp_t got_r_q;
    int         n_got_q;
    // the transmitter has no back-pressure, so every pulse is taken
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            n_got_q <= 0;
        end else if (mix_out.valid) begin
            got_l_q <= mix_out.left;
            got_r_q <= mix_out.right;
            n_got_q <= n_got_q + 1;
        end
    end
endmodule // apmix_sink

// file: test/apmix_top_sva.sv
// port-level assertions for the port-1 output mixer
module apmix_top_sva (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic [11:0]           s_axi_awaddr,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic [31:0]           s_axi_wdata,
    input wire logic [3:0]            s_axi_wstrb,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [11:0]           s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire apmix_pkg::apmix_src_t src_in,
    input wire apmix_pkg::apmix_out_t mix_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import apmix_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // stream timing: every strobe gives one result two edges on, and nothing else does
    out_latency_a: assert property (src_in.valid |-> ##2 mix_out.valid)
        else $error("mix result missing two cycles after strobe");
    out_cause_a: assert property (mix_out.valid |-> $past(src_in.valid, 2))
        else $error("mix result without a strobe");
    out_hold_a: assert property (!mix_out.valid |-> $stable(mix_out.left) && $stable(mix_out.right))
        else $error("mix output moved between results");
    // bus answers stand until taken, and a pending write answer blocks new writes meanwhile
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    src_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h170
        |=> s_axi_rdata[31:7] == 25'h0)
        else $error("source select reads reserved bits set");
endmodule // apmix_top_sva

bind apmix_top apmix_top_sva chk (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .src_in, .mix_out);

// file: test/apmix_top_bench.sv
// self-checking bench for the port-1 output mixer
module apmix_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import apmix_pkg::*;
    typedef struct packed {
        logic [7:0]  src;
        logic [2:0]  path;
        logic [4:0]  code;
        logic [23:0] exp;
    } apmix_row_t;
    logic              clock, rst_n;
    logic [11:0]       s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    apmix_src_t        src_in;
    apmix_out_t        mix_out;
    int                failures = 0, n_compared = 0, cycles = 0;
    // one distinct bit per input, so the sum shows which paths were mixed
    logic [6:0][23:0]  base = {24'h004000, 24'h002000, 24'h001000, 24'h000800,
                               24'h000400, 24'h000200, 24'h000100};
    // left bitmap, gain path, gain code, left result; right stays at its reset mix
    apmix_row_t        rows [10] = '{
        {8'h01, 3'h0, 5'h1C, 24'h000100}, {8'h7F, 3'h0, 5'h1C, 24'h007F00},
        {8'hFF, 3'h0, 5'h1C, 24'h007F00}, {8'h10, 3'h4, 5'h00, 24'h000020},
        {8'h10, 3'h4, 5'h1F, 24'h001ADC}, {8'h40, 3'h6, 5'h00, 24'h000082},
        {8'h40, 3'h6, 5'h1F, 24'h006B71}, {8'h20, 3'h6, 5'h00, 24'h002000},
        {8'h00, 3'h0, 5'h1C, 24'h000000}, {8'h2A, 3'h1, 5'h1C, 24'h002A00}};

    apmix_top uut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .src_in, .mix_out);
    apmix_sink sink (.clock, .rst_n, .mix_out);

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic give_verdict;
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic chk_smp(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    // bready is raised only once the answer shows, so the hold phase is exercised
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge clock);
        s_axi_bready <= 1'b0;
        chk_reg("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge clock);
        s_axi_rready <= 1'b0;
        chk_reg("rdata", e, s_axi_rdata);
        chk_reg("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // one-cycle strobe, then wait for the transmitter to take the result
    task automatic send(input logic [6:0][23:0] v);
        int n0;
        n0 = sink.n_got_q;
        @(posedge clock);
        src_in <= {1'b1, v};
        @(posedge clock);
        src_in.valid <= 1'b0;
        while (sink.n_got_q == n0) @(posedge clock);
    endtask

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        src_in = '0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            axi_read({10'h05C + 10'(i), 2'h0}, (i == 0) ? 32'h1 : (i == 8) ? 32'h4 : 32'h1C, 2'h0);
        end
        axi_read(12'h000, 32'h0, 2'h2);
        axi_write(12'h000, 32'h7F, 4'hF, 2'h2);
        axi_write(12'h170, 32'h7F, 4'h0, 2'h0);
        axi_read(12'h170, 32'h1, 2'h0);
        foreach (rows[i]) begin
            axi_write(12'h170, {24'h0, rows[i].src}, 4'hF, 2'h0);
            axi_read(12'h170, {24'h0, rows[i].src & 8'h7F}, 2'h0);
            axi_write({10'h05D + 10'(rows[i].path), 2'h0}, {27'h0, rows[i].code}, 4'hF, 2'h0);
            send(base);
            chk_smp("left mix", rows[i].exp, sink.got_l_q);
            chk_smp("right mix", 24'h000400, sink.got_r_q);
            axi_write({10'h05D + 10'(rows[i].path), 2'h0}, 32'h1C, 4'hF, 2'h0);
        end
        // half-scale inputs on all seven paths must saturate, right stays single
        axi_write(12'h170, 32'h7F, 4'hF, 2'h0);
        send({7{24'h400000}});
        chk_smp("left sat", 24'h7FFFFF, sink.got_l_q);
        chk_smp("right single", 24'h400000, sink.got_r_q);
        axi_read(12'h3C0, 32'h1, 2'h0);
        axi_write(12'h3C0, 32'h1, 4'hF, 2'h0);
        axi_read(12'h3C0, 32'h0, 2'h0);
        // second reset in mid-run brings the configuration back
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        axi_read(12'h170, 32'h1, 2'h0);
        axi_read(12'h178, 32'h1C, 2'h0);
        give_verdict();
    end
endmodule // apmix_top_bench
